// file: core/edge_delay.sv
`timescale 1ns/1ps
module edge_delay
	import leg_pkg::*;
#(
	parameter int   W          = DT_W,
	parameter logic DELAY_RISE = 1'b1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         din,
	input  wire logic [W-1:0] dead_cycles,
	output logic              dout,
	output logic              busy
);

	// ---------------------------------------------------------------
	// edge classification
	// ---------------------------------------------------------------
	logic [W-1:0] cnt;
	wire          differs   = din != dout;
	wire          delayed   = differs && (din == DELAY_RISE);
	wire          release_e = delayed && (cnt >= dead_cycles);
	wire [W-1:0]  next_cnt  = delayed && !release_e ? cnt + 1'b1 : '0;

	assign busy = differs;

	// ---------------------------------------------------------------
	// the delayed edge waits for the count, the other passes at once;
	// a pulse shorter than the deadtime restarts the wait
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout <= GATE_RESET;
			cnt  <= '0;
		end else begin
			cnt  <= next_cnt;
			if (differs && (!delayed || release_e))
				dout <= din;
		end
	end

endmodule

// file: core/leg_pkg.sv
package leg_pkg;

	// ---------------------------------------------------------------
	// clock and deadtime timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 10;
	localparam int DT_W                = 8;
	// plain default deadtime, rounded up to whole clock cycles below
	localparam int DEFAULT_DEADTIME_NS = 200;
	localparam int DEFAULT_DEAD_CYCLES =
		(DEFAULT_DEADTIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [DT_W-1:0] MIN_DEAD_CYCLES = 8'h01;

	// ---------------------------------------------------------------
	// pin group positions and reset values
	// ---------------------------------------------------------------
	localparam int PIN_COUNT     = 5;
	localparam int PIN_UPPER     = 0;
	localparam int PIN_LOWER     = 1;
	localparam int PIN_ENABLE    = 2;
	localparam int PIN_EMERGENCY = 3;
	localparam int PIN_LEG_KIND  = 4;
	localparam logic GATE_RESET  = 1'b0;
	localparam logic FLAG_RESET  = 1'b0;

	// ---------------------------------------------------------------
	// state encodings
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CTL_OFF   = 3'b001,
		CTL_RUN   = 3'b010,
		CTL_DRAIN = 3'b100
	} ctl_e;

	typedef enum logic [6:0] {
		LEG_OFF     = 7'h01,
		LEG_CLAMP   = 7'h02,
		LEG_UPPER   = 7'h04,
		LEG_LOWER   = 7'h08,
		LEG_DT_UP   = 7'h10,
		LEG_DT_LOW  = 7'h20,
		LEG_UNSAFE  = 7'h40
	} leg_e;

endpackage

// file: core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule

// file: core/three_level_leg_interlock.sv
`timescale 1ns/1ps
module three_level_leg_interlock
	import leg_pkg::*;
#(
	parameter int DEAD_W = DT_W
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              mod_upper,
	input  wire logic              mod_lower,
	input  wire logic              enable_req,
	input  wire logic              emergency_off,
	input  wire logic              leg_kind_tclamp,
	input  wire logic [DEAD_W-1:0] dead_cycles,
	input  wire logic              flag_clear,
	output logic                   outer_upper_gate_cmd,
	output logic                   inner_upper_gate_cmd,
	output logic                   inner_lower_gate_cmd,
	output logic                   outer_lower_gate_cmd,
	output logic [6:0]             leg_state,
	output logic                   override_active,
	output logic                   drain_busy,
	output logic                   disallowed_seen,
	output logic                   double_toggle_seen
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins;

	assign pins_raw[PIN_UPPER]     = mod_upper;
	assign pins_raw[PIN_LOWER]     = mod_lower;
	assign pins_raw[PIN_ENABLE]    = enable_req;
	assign pins_raw[PIN_EMERGENCY] = emergency_off;
	assign pins_raw[PIN_LEG_KIND]  = leg_kind_tclamp;

	pin_sync #(
		.W (PIN_COUNT)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (pins_raw),
		.dout  (pins)
	);

	wire up_s    = pins[PIN_UPPER];
	wire low_s   = pins[PIN_LOWER];
	wire en_s    = pins[PIN_ENABLE];
	wire emerg_s = pins[PIN_EMERGENCY];
	wire tclamp  = pins[PIN_LEG_KIND];

	// ---------------------------------------------------------------
	// state decode of the four gate commands
	// ---------------------------------------------------------------
	function automatic leg_e decode_leg(
		input logic ou,
		input logic iu,
		input logic il,
		input logic ol
	);
		unique case ({ou, iu, il, ol})
			4'b0000: decode_leg = LEG_OFF;
			4'b0110: decode_leg = LEG_CLAMP;
			4'b1100: decode_leg = LEG_UPPER;
			4'b0011: decode_leg = LEG_LOWER;
			4'b0100: decode_leg = LEG_DT_UP;
			4'b0010: decode_leg = LEG_DT_LOW;
			default: decode_leg = LEG_UNSAFE;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// deadtime value
	// ---------------------------------------------------------------
	// zero would remove the gap entirely, so it is lifted to one cycle
	wire [DEAD_W-1:0] dead_eff = (dead_cycles < DEAD_W'(MIN_DEAD_CYCLES))
		? DEAD_W'(MIN_DEAD_CYCLES) : dead_cycles;

	// ---------------------------------------------------------------
	// control sequence
	// ---------------------------------------------------------------
	ctl_e               ctl;
	ctl_e               next_ctl;
	logic [DEAD_W-1:0]  drain_cnt;
	logic [DEAD_W-1:0]  next_drain_cnt;
	logic               rise_up;
	logic               rise_low;
	logic               fall_up;
	logic               fall_low;
	logic               busy_ru;
	logic               busy_rl;
	logic               busy_fu;
	logic               busy_fl;

	wire stop_req    = !en_s || emerg_s;
	wire inputs_low  = !up_s && !low_s;
	wire delays_idle = !busy_ru && !busy_rl && !busy_fu && !busy_fl;
	wire drain_done  = delays_idle && (drain_cnt >= dead_eff);

	always_comb begin
		next_ctl = ctl;
		unique case (ctl)
			CTL_OFF: begin
				// leave the override only with both inputs low
				if (!stop_req && inputs_low)
					next_ctl = CTL_RUN;
			end
			CTL_RUN: begin
				if (stop_req && tclamp)
					next_ctl = CTL_OFF;
				else if (stop_req)
					next_ctl = CTL_DRAIN;
			end
			CTL_DRAIN: begin
				if (drain_done)
					next_ctl = CTL_OFF;
			end
		endcase
	end

	// drain count runs only once all edges have settled low
	assign next_drain_cnt = (ctl == CTL_DRAIN && delays_idle && !drain_done)
		? drain_cnt + 1'b1 : '0;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl       <= CTL_OFF;
			drain_cnt <= '0;
		end else begin
			ctl       <= next_ctl;
			drain_cnt <= next_drain_cnt;
		end
	end

	// ---------------------------------------------------------------
	// qualified modulation
	// ---------------------------------------------------------------
	// a disallowed 11 is steered toward the clamp state rather than
	// trusted; while draining or off the inputs are held low
	wire both_high = up_s && low_s;
	wire mod_pass  = (ctl == CTL_RUN) && !both_high;
	wire q_up      = mod_pass && up_s;
	wire q_low     = mod_pass && low_s;

	// ---------------------------------------------------------------
	// edge delays: rising for outer, falling for inner
	// ---------------------------------------------------------------
	edge_delay #(
		.W          (DEAD_W),
		.DELAY_RISE (1'b1)
	) u_rise_up (
		.clk         (clk),
		.rst_b       (rst_b),
		.din         (q_up),
		.dead_cycles (dead_eff),
		.dout        (rise_up),
		.busy        (busy_ru)
	);

	edge_delay #(
		.W          (DEAD_W),
		.DELAY_RISE (1'b0)
	) u_fall_up (
		.clk         (clk),
		.rst_b       (rst_b),
		.din         (q_up),
		.dead_cycles (dead_eff),
		.dout        (fall_up),
		.busy        (busy_fu)
	);

	edge_delay #(
		.W          (DEAD_W),
		.DELAY_RISE (1'b1)
	) u_rise_low (
		.clk         (clk),
		.rst_b       (rst_b),
		.din         (q_low),
		.dead_cycles (dead_eff),
		.dout        (rise_low),
		.busy        (busy_rl)
	);

	edge_delay #(
		.W          (DEAD_W),
		.DELAY_RISE (1'b0)
	) u_fall_low (
		.clk         (clk),
		.rst_b       (rst_b),
		.din         (q_low),
		.dead_cycles (dead_eff),
		.dout        (fall_low),
		.busy        (busy_fl)
	);

	// ---------------------------------------------------------------
	// gate mapping and interlock
	// ---------------------------------------------------------------
	// the outer gate rises a deadtime after the inner gate of its
	// own pair has already dropped, and the inner gate returns
	// only a deadtime after the outer one has gone off
	wire gates_on   = ctl != CTL_OFF;
	wire next_ou    = gates_on && rise_up && !rise_low;
	wire next_ol    = gates_on && rise_low && !rise_up;
	wire next_il    = gates_on && !fall_up;
	wire next_iu    = gates_on && !fall_low;
	// inner gates come up with release before any outer one can
	// follow, and in a drain they stay on until the final drop

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			outer_upper_gate_cmd <= GATE_RESET;
			inner_upper_gate_cmd <= GATE_RESET;
			inner_lower_gate_cmd <= GATE_RESET;
			outer_lower_gate_cmd <= GATE_RESET;
		end else begin
			outer_upper_gate_cmd <= next_ou;
			inner_upper_gate_cmd <= next_iu;
			inner_lower_gate_cmd <= next_il;
			outer_lower_gate_cmd <= next_ol;
		end
	end

	// ---------------------------------------------------------------
	// state report
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			leg_state       <= LEG_OFF;
			override_active <= 1'b1;
			drain_busy      <= 1'b0;
		end else begin
			leg_state       <= decode_leg(next_ou, next_iu,
				next_il, next_ol);
			override_active <= next_ctl == CTL_OFF;
			drain_busy      <= next_ctl == CTL_DRAIN;
		end
	end

	// ---------------------------------------------------------------
	// source misbehaviour flags
	// ---------------------------------------------------------------
	// these only report; the gate path above already tolerates both.
	// a new event in the clearing cycle keeps the flag set
	logic up_prev;
	logic low_prev;

	wire dbl_toggle = (up_s != up_prev) && (low_s != low_prev);
	wire next_dis   = both_high || (disallowed_seen && !flag_clear);
	wire next_dbl   = dbl_toggle
		|| (double_toggle_seen && !flag_clear);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			up_prev            <= 1'b0;
			low_prev           <= 1'b0;
			disallowed_seen    <= FLAG_RESET;
			double_toggle_seen <= FLAG_RESET;
		end else begin
			up_prev            <= up_s;
			low_prev           <= low_s;
			disallowed_seen    <= next_dis;
			double_toggle_seen <= next_dbl;
		end
	end

endmodule

// file: dv/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] gate_in,
	output logic      [3:0] sw_on,
	output logic            sw_fault
);
	// ---------------------------------------------------------------
	// one cycle through the isolation barrier; short is sticky
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_on    <= 4'h0;
			sw_fault <= 1'b0;
		end else begin
			sw_on <= gate_in;
			if ((gate_in[3] && (gate_in[0] || gate_in[1])) ||
				(gate_in[2] && gate_in[0]))
				sw_fault <= 1'b1;
		end
	end
endmodule

// file: dv/three_level_leg_interlock_sva.sv
`timescale 1ns/1ps
module leg_interlock_chk
	import leg_pkg::*;
#(
	parameter int DEAD_W = DT_W
) (
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic [DEAD_W-1:0] dead_cycles,
	input wire logic              outer_upper_gate_cmd,
	input wire logic              inner_upper_gate_cmd,
	input wire logic              inner_lower_gate_cmd,
	input wire logic              outer_lower_gate_cmd,
	input wire logic [6:0]        leg_state,
	input wire logic              override_active
);
	logic [3:0] g;
	logic [7:0] low_cnt [4];
	logic [7:0] dead;
	logic [6:0] decoded;

	assign g = {outer_upper_gate_cmd, inner_upper_gate_cmd,
		inner_lower_gate_cmd, outer_lower_gate_cmd};
	assign dead = (dead_cycles == '0) ? 8'h01 : 8'(dead_cycles);
	assign decoded = (g == 4'h0) ? LEG_OFF : (g == 4'h6) ? LEG_CLAMP :
		(g == 4'hC) ? LEG_UPPER : (g == 4'h3) ? LEG_LOWER :
		(g == 4'h4) ? LEG_DT_UP : (g == 4'h2) ? LEG_DT_LOW : LEG_UNSAFE;

	// ---------------------------------------------------------------
	// off-time per gate; saturates so reset counts as long off
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		for (int i = 0; i < 4; i++) begin
			if (!rst_b)
				low_cnt[i] <= 8'hFF;
			else if (g[i])
				low_cnt[i] <= 8'h00;
			else if (low_cnt[i] != 8'hFF)
				low_cnt[i] <= low_cnt[i] + 8'h01;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence clamp_next_s;
		##1 (leg_state == LEG_CLAMP);
	endsequence

	outer_excl_a: assert property (!(g[3] && g[0]))
		else $error("both outer gates on");
	pair_excl_a: assert property (!(g[3] && g[1]) && !(g[2] && g[0]))
		else $error("pair members on together");
	state_decode_a: assert property (leg_state == decoded)
		else $error("leg state does not match gates");
	override_off_a: assert property (override_active |=> g == 4'h0)
		else $error("gate on under override");
	reset_off_a: assert property (
		$rose(rst_b) |-> override_active && g == 0)
		else $error("reset state wrong");
	clamp_step_a: assert property (
		leg_state == LEG_CLAMP |=> leg_state inside
		{LEG_CLAMP, LEG_DT_UP, LEG_DT_LOW, LEG_OFF})
		else $error("clamp left without deadtime state");
	outer_dead_a: assert property (
		(!$rose(g[3]) || low_cnt[1] >= dead) &&
		(!$rose(g[0]) || low_cnt[2] >= dead))
		else $error("outer gate on before deadtime");
	inner_dead_a: assert property (
		(!$rose(g[1]) || low_cnt[3] >= dead) &&
		(!$rose(g[2]) || low_cnt[0] >= dead))
		else $error("inner gate on before deadtime");
	inner_first_a: assert property ((!$rose(g[3]) || g[2]) &&
		(!$rose(g[0]) || g[1]))
		else $error("outer on without its inner");
	release_clamp_a: assert property (
		$fell(override_active) |-> clamp_next_s)
		else $error("release did not enter clamp");
endmodule

// file: dv/three_level_leg_interlock_tb.sv
`timescale 1ns/1ps
module three_level_leg_interlock_tb;
	import leg_pkg::*;
	logic       clk, rst_b, mod_upper, mod_lower, enable_req;
	logic       emergency_off, leg_kind_tclamp, flag_clear;
	logic [7:0] dead_cycles;
	logic       ou, iu, il, ol, override_active, drain_busy;
	logic       dis_seen, dbl_seen, sw_fault;
	logic [3:0] sw_on;
	logic [6:0] leg_state;
	int         n_fail, cmp_count, cyc, exp_d;

	three_level_leg_interlock #(.DEAD_W(8)) u_dut (
		.clk(clk), .rst_b(rst_b), .mod_upper(mod_upper),
		.mod_lower(mod_lower), .enable_req(enable_req),
		.emergency_off(emergency_off), .leg_kind_tclamp(leg_kind_tclamp),
		.dead_cycles(dead_cycles), .flag_clear(flag_clear),
		.outer_upper_gate_cmd(ou), .inner_upper_gate_cmd(iu),
		.inner_lower_gate_cmd(il), .outer_lower_gate_cmd(ol),
		.leg_state(leg_state), .override_active(override_active),
		.drain_busy(drain_busy), .disallowed_seen(dis_seen),
		.double_toggle_seen(dbl_seen));
	gate_driver_model u_drv (.clk(clk), .rst_b(rst_b),
		.gate_in({ou, iu, il, ol}), .sw_on(sw_on), .sw_fault(sw_fault));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			$display("ERROR %0t run timed out", $time);
			tally_and_finish();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input bit ok, input string msg);
		cmp_count++;
		if (!ok) begin
			n_fail++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	// waits until both gates of one pair have moved; gap in cycles
	task automatic pair_move(input bit up, output int gap,
		output logic [6:0] mid);
		logic [1:0] s0, s;
		int t1;
		s0 = up ? {ou, il} : {ol, iu};
		t1 = -1;
		gap = -1;
		mid = 'x;
		for (int i = 0; i < 40 && gap < 0; i++) begin
			tick(1);
			s = up ? {ou, il} : {ol, iu};
			if (t1 < 0 && s !== s0) begin
				t1 = i;
				mid = leg_state;
			end
			if (s === ~s0)
				gap = i - t1;
		end
	endtask

	task automatic t_start();
		emergency_off = 1'b0;
		mod_upper = 1'b1;
		enable_req = 1'b1;
		tick(10);
		chk(override_active === 1'b1, "start with input high");
		mod_upper = 1'b0;
		for (int i = 0; i < 20 && leg_state !== LEG_CLAMP; i++)
			tick(1);
		chk(leg_state === LEG_CLAMP && !override_active, "start");
		$display("test start done");
	endtask

	task automatic t_rail(input bit up);
		int gap;
		logic [6:0] mid;
		if (up)
			mod_upper = 1'b1;
		else
			mod_lower = 1'b1;
		pair_move(up, gap, mid);
		chk(gap === exp_d, "on deadtime");
		chk(mid === (up ? LEG_DT_UP : LEG_DT_LOW), "on step");
		chk(leg_state === (up ? LEG_UPPER : LEG_LOWER), "rail");
		mod_upper = 1'b0;
		mod_lower = 1'b0;
		pair_move(up, gap, mid);
		chk(gap === exp_d, "off deadtime");
		chk(mid === (up ? LEG_DT_UP : LEG_DT_LOW), "off step");
		chk(leg_state === LEG_CLAMP, "clamp");
		$display("test rail %0d done", up);
	endtask

	task automatic t_bad();
		mod_upper = 1'b1;
		tick(12);
		mod_lower = 1'b1;
		tick(12);
		chk(dis_seen === 1'b1 && leg_state === LEG_CLAMP, "both high");
		// a clear that meets a live cause must not win
		flag_clear = 1'b1;
		tick(1);
		flag_clear = 1'b0;
		chk(dis_seen === 1'b1, "set over clear");
		mod_lower = 1'b0;
		tick(12);
		flag_clear = 1'b1;
		tick(1);
		flag_clear = 1'b0;
		tick(2);
		chk(dis_seen === 1'b0, "flag clear");
		mod_upper = 1'b0;
		mod_lower = 1'b1;
		tick(4);
		chk(dbl_seen === 1'b1, "double toggle");
		mod_lower = 1'b0;
		tick(12);
		$display("test bad source done");
	endtask

	task automatic t_shut(input bit emerg);
		int t1, t2;
		bit drained;
		t1 = -1;
		t2 = -1;
		drained = 0;
		mod_upper = 1'b1;
		tick(15);
		if (emerg)
			emergency_off = 1'b1;
		else
			enable_req = 1'b0;
		for (int i = 0; i < 60 && t2 < 0; i++) begin
			tick(1);
			drained |= (drain_busy === 1'b1);
			if (t1 < 0 && ou === 1'b0)
				t1 = i;
			if ({ou, iu, il, ol} === 4'h0)
				t2 = i;
		end
		mod_upper = 1'b0;
		if (leg_kind_tclamp)
			chk(t2 === t1 && t2 >= 0, "drop at once");
		else
			chk(t2 - t1 > exp_d && drained, "delayed off");
		chk(override_active === 1'b1 && leg_state === LEG_OFF, "off");
		$display("test shutdown %0d done", emerg);
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		{clk, rst_b, mod_upper, mod_lower, enable_req} = 5'h00;
		{emergency_off, leg_kind_tclamp, flag_clear} = 3'h0;
		dead_cycles = 8'h03;
		exp_d = 3;
		tick(5);
		chk(override_active === 1'b1 && leg_state === LEG_OFF, "reset");
		rst_b = 1'b1;
		t_start();
		t_rail(1'b1);
		t_rail(1'b0);
		t_bad();
		t_shut(1'b0);
		t_start();
		t_shut(1'b1);
		leg_kind_tclamp = 1'b1;
		dead_cycles = 8'h00;
		exp_d = 1;
		tick(4);
		t_start();
		t_rail(1'b1);
		t_shut(1'b0);
		// driver model lags the gates by one edge
		tick(2);
		chk(sw_fault === 1'b0 && sw_on === 4'h0, "driver short");
		tally_and_finish();
	end
endmodule

bind three_level_leg_interlock leg_interlock_chk #(.DEAD_W(DEAD_W)) u_chk (
	.clk(clk), .rst_b(rst_b), .dead_cycles(dead_cycles),
	.outer_upper_gate_cmd(outer_upper_gate_cmd),
	.inner_upper_gate_cmd(inner_upper_gate_cmd),
	.inner_lower_gate_cmd(inner_lower_gate_cmd),
	.outer_lower_gate_cmd(outer_lower_gate_cmd),
	.leg_state(leg_state), .override_active(override_active));
